/* hw/qbp_pkg.sv */
// Package for the two 4-bit bidirectional ports and their SFR map
package qbp_pkg;

   localparam int unsigned QBP_WIDTH = 4;
   localparam int unsigned QBP_ADDR_W = 8;

   // SFR nibble addresses
   localparam logic [7:0] QBP_ADDR_A_DATA      = 8'h0A;
   localparam logic [7:0] QBP_ADDR_B_DATA      = 8'h0B;
   localparam logic [7:0] QBP_ADDR_A_MODE_LO   = 8'h2A;
   localparam logic [7:0] QBP_ADDR_A_MODE_HI   = 8'h2B;
   localparam logic [7:0] QBP_ADDR_A_DIR       = 8'h2C;
   localparam logic [7:0] QBP_ADDR_B_MODE_LO   = 8'h2E;
   localparam logic [7:0] QBP_ADDR_B_MODE_HI   = 8'h2F;
   localparam logic [7:0] QBP_ADDR_B_DIR       = 8'h30;
   localparam logic [7:0] QBP_ADDR_B_IRQ_EN    = 8'h31;

   // Reset values
   localparam logic [3:0] QBP_RST_DATA = 4'h0;
   localparam logic [3:0] QBP_RST_DIR  = 4'h0;
   localparam logic [3:0] QBP_RST_MODE = 4'h0;
   localparam logic [3:0] QBP_RST_IRQ  = 4'h0;

   // Input mode codes (low bit set means high impedance)
   localparam logic [1:0] QBP_IN_PULL_DOWN = 2'h0;
   localparam logic [1:0] QBP_IN_PULL_UP   = 2'h2;

   // Output mode codes
   localparam logic [1:0] QBP_OUT_CMOS   = 2'h0;
   localparam logic [1:0] QBP_OUT_NOD    = 2'h1;
   localparam logic [1:0] QBP_OUT_POD    = 2'h2;
   localparam logic [1:0] QBP_OUT_HIZ    = 2'h3;

   // Synchroniser depth
   localparam int unsigned QBP_SYNC_STAGES = 2;

   // SFR access from the core
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [3:0] wdata;
   } qbp_sfr_req_t;

   // Pad controls for one port
   typedef struct packed {
      logic [3:0] out;
      logic [3:0] oe;
      logic [3:0] pull_up;
      logic [3:0] pull_down;
   } qbp_pad_t;

   // Pin behaviour from direction, mode and data
   function automatic void qbp_pin_ctl(
      input  logic       dir,
      input  logic [1:0] mode,
      input  logic       data,
      output logic       oe,
      output logic       pu,
      output logic       pd
   );
      oe = 1'b0;
      pu = 1'b0;
      pd = 1'b0;
      if (dir) begin
         unique case (mode)
            QBP_OUT_CMOS: oe = 1'b1;
            QBP_OUT_NOD:  oe = ~data;
            QBP_OUT_POD:  oe = data;
            QBP_OUT_HIZ:  oe = 1'b0;
         endcase
      end else if (!mode[0]) begin
         pu = (mode == QBP_IN_PULL_UP);
         pd = (mode == QBP_IN_PULL_DOWN);
      end
   endfunction

endpackage

/* hw/qbp_sync.sv */
// Two-flop synchroniser bank for pin levels
`timescale 1ns/100ps
module qbp_sync #(
   parameter int unsigned WIDTH = 4
) (
   // Clock and reset
   input  wire logic             clock_in,
   input  wire logic             rst_in,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] sync_r;
   logic [WIDTH-1:0] sync_nxt;

   initial begin
      if (WIDTH < 1) $error("qbp_sync: WIDTH must be at least 1");
   end

   always_comb begin
      meta_nxt = async_in;
      sync_nxt = meta_r;
   end

   // First stage feeds only the second
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign sync_out = sync_r;
endmodule // qbp_sync

/* hw/qbp_port_pair.sv */
// Two 4-bit bidirectional ports A and B with external interrupt 0
//
// Operation
// R01: Each port has writable 4-bit output data
// R02: Direction one drives output data onto pin
// R03: Output pins read back stored data bit
// R04: Input pins read back sampled pin level
// R05: Reset clears all output data bits
// R06: Pins change at write's state-2 clock edge
// R07: Direction register: zero input, one output
// R08: Reset clears direction; all pins inputs
// R09: Two mode registers, 2-bit field per pin
// R10: Input codes: pull-down, pull-up, high impedance
// R11: Output codes: CMOS, N-drain, P-drain, Hi-Z
// R12: External interrupt 0 ORs port B inputs
// R13: Per-pin enable gates interrupt 0 OR
// R14: Pin levels synchronised before any use
`timescale 1ns/100ps
module qbp_port_pair
   import qbp_pkg::*;
#(
   parameter int unsigned WIDTH = 4
) (
   // Clock and reset
   input  wire logic             clock_in,
   input  wire logic             rst_in,
   // SFR bus from the core
   input  wire qbp_pkg::qbp_sfr_req_t sfr_req_in,
   output logic      [3:0]       sfr_rdata_out,
   output logic                  sfr_hit_out,
   // Port A pins
   input  wire logic [3:0]       port_a_pin_in,
   output qbp_pkg::qbp_pad_t     port_a_pad_out,
   // Port B pins
   input  wire logic [3:0]       port_b_pin_in,
   output qbp_pkg::qbp_pad_t     port_b_pad_out,
   // External interrupt 0 level
   output logic                  external_irq_zero_out
);
   import qbp_pkg::*;

   initial begin
      if (WIDTH != QBP_WIDTH) $error("qbp_port_pair: WIDTH must be 4");
   end

   // Register state
   logic [3:0] port_a_output_data_r;
   logic [3:0] port_a_output_data_nxt;
   logic [3:0] port_b_output_data_r;
   logic [3:0] port_b_output_data_nxt;
   logic [3:0] port_a_direction_r;
   logic [3:0] port_a_direction_nxt;
   logic [3:0] port_b_direction_r;
   logic [3:0] port_b_direction_nxt;
   logic [3:0] port_a_mode_low_pins_r;
   logic [3:0] port_a_mode_low_pins_nxt;
   logic [3:0] port_a_mode_high_pins_r;
   logic [3:0] port_a_mode_high_pins_nxt;
   logic [3:0] port_b_mode_low_pins_r;
   logic [3:0] port_b_mode_low_pins_nxt;
   logic [3:0] port_b_mode_high_pins_r;
   logic [3:0] port_b_mode_high_pins_nxt;
   logic [3:0] port_b_irq_enables_r;
   logic [3:0] port_b_irq_enables_nxt;
   logic [3:0] rdata_r;
   logic [3:0] rdata_nxt;
   logic       irq_r;
   logic       irq_nxt;
   qbp_pad_t   pad_a_r;
   qbp_pad_t   pad_a_nxt;
   qbp_pad_t   pad_b_r;
   qbp_pad_t   pad_b_nxt;

   logic [3:0] pin_a_sync;
   logic [3:0] pin_b_sync;
   logic       hit;

   // Pins are asynchronous to the core clock
   qbp_sync #(.WIDTH(8)) u_sync (  // R14
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .async_in ({port_b_pin_in, port_a_pin_in}),
      .sync_out ({pin_b_sync, pin_a_sync})
   );

   // Read mux: stored bit for outputs, pin level for inputs
   function automatic logic [3:0] qbp_readback(
      input logic [3:0] dir,
      input logic [3:0] data,
      input logic [3:0] pins
   );
      qbp_readback = (dir & data) | (~dir & pins); // R03 R04
   endfunction

   // Build pad controls for one port from its registers
   function automatic qbp_pad_t qbp_pads(
      input logic [3:0] dir,
      input logic [3:0] data,
      input logic [3:0] mode_lo,
      input logic [3:0] mode_hi
   );
      logic [7:0] modes;
      logic       oe;
      logic       pu;
      logic       pd;
      modes = {mode_hi, mode_lo}; // R09
      qbp_pads.out = data;
      qbp_pads.oe = '0;
      qbp_pads.pull_up = '0;
      qbp_pads.pull_down = '0;
      for (int i = 0; i < 4; i++) begin
         qbp_pin_ctl(dir[i], modes[2*i +: 2], data[i], oe, pu, pd); // R10 R11
         qbp_pads.oe[i] = oe; // R02
         qbp_pads.pull_up[i] = pu;
         qbp_pads.pull_down[i] = pd;
      end
   endfunction

   // Register writes
   always_comb begin
      port_a_output_data_nxt    = port_a_output_data_r;
      port_b_output_data_nxt    = port_b_output_data_r;
      port_a_direction_nxt      = port_a_direction_r;
      port_b_direction_nxt      = port_b_direction_r;
      port_a_mode_low_pins_nxt  = port_a_mode_low_pins_r;
      port_a_mode_high_pins_nxt = port_a_mode_high_pins_r;
      port_b_mode_low_pins_nxt  = port_b_mode_low_pins_r;
      port_b_mode_high_pins_nxt = port_b_mode_high_pins_r;
      port_b_irq_enables_nxt    = port_b_irq_enables_r;
      if (sfr_req_in.wr) begin
         unique case (sfr_req_in.addr)
            QBP_ADDR_A_DATA:    port_a_output_data_nxt = sfr_req_in.wdata; // R01
            QBP_ADDR_B_DATA:    port_b_output_data_nxt = sfr_req_in.wdata; // R01
            QBP_ADDR_A_DIR:     port_a_direction_nxt = sfr_req_in.wdata; // R07
            QBP_ADDR_B_DIR:     port_b_direction_nxt = sfr_req_in.wdata; // R07
            QBP_ADDR_A_MODE_LO: port_a_mode_low_pins_nxt = sfr_req_in.wdata;
            QBP_ADDR_A_MODE_HI: port_a_mode_high_pins_nxt = sfr_req_in.wdata;
            QBP_ADDR_B_MODE_LO: port_b_mode_low_pins_nxt = sfr_req_in.wdata;
            QBP_ADDR_B_MODE_HI: port_b_mode_high_pins_nxt = sfr_req_in.wdata;
            QBP_ADDR_B_IRQ_EN:  port_b_irq_enables_nxt = sfr_req_in.wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         port_a_output_data_r    <= QBP_RST_DATA; // R05
         port_b_output_data_r    <= QBP_RST_DATA; // R05
         port_a_direction_r      <= QBP_RST_DIR; // R08
         port_b_direction_r      <= QBP_RST_DIR; // R08
         port_a_mode_low_pins_r  <= QBP_RST_MODE;
         port_a_mode_high_pins_r <= QBP_RST_MODE;
         port_b_mode_low_pins_r  <= QBP_RST_MODE;
         port_b_mode_high_pins_r <= QBP_RST_MODE;
         port_b_irq_enables_r    <= QBP_RST_IRQ;
      end else begin
         port_a_output_data_r    <= port_a_output_data_nxt;
         port_b_output_data_r    <= port_b_output_data_nxt;
         port_a_direction_r      <= port_a_direction_nxt;
         port_b_direction_r      <= port_b_direction_nxt;
         port_a_mode_low_pins_r  <= port_a_mode_low_pins_nxt;
         port_a_mode_high_pins_r <= port_a_mode_high_pins_nxt;
         port_b_mode_low_pins_r  <= port_b_mode_low_pins_nxt;
         port_b_mode_high_pins_r <= port_b_mode_high_pins_nxt;
         port_b_irq_enables_r    <= port_b_irq_enables_nxt;
      end
   end

   // Read path; unmapped addresses read zero with no hit
   always_comb begin
      hit = 1'b1;
      rdata_nxt = 4'h0;
      unique case (sfr_req_in.addr)
         QBP_ADDR_A_DATA: rdata_nxt = qbp_readback(port_a_direction_r,
            port_a_output_data_r, pin_a_sync);
         QBP_ADDR_B_DATA: rdata_nxt = qbp_readback(port_b_direction_r,
            port_b_output_data_r, pin_b_sync);
         QBP_ADDR_A_DIR:     rdata_nxt = port_a_direction_r;
         QBP_ADDR_B_DIR:     rdata_nxt = port_b_direction_r;
         QBP_ADDR_A_MODE_LO: rdata_nxt = port_a_mode_low_pins_r;
         QBP_ADDR_A_MODE_HI: rdata_nxt = port_a_mode_high_pins_r;
         QBP_ADDR_B_MODE_LO: rdata_nxt = port_b_mode_low_pins_r;
         QBP_ADDR_B_MODE_HI: rdata_nxt = port_b_mode_high_pins_r;
         QBP_ADDR_B_IRQ_EN:  rdata_nxt = port_b_irq_enables_r;
         default:            hit = 1'b0;
      endcase
      if (!sfr_req_in.rd) begin
         rdata_nxt = 4'h0;
      end
   end

   // Pads registered: a write in state 1 shows at the edge that ends state 2
   always_comb begin
      pad_a_nxt = qbp_pads(port_a_direction_r, port_a_output_data_r,
         port_a_mode_low_pins_r, port_a_mode_high_pins_r);
      pad_b_nxt = qbp_pads(port_b_direction_r, port_b_output_data_r,
         port_b_mode_low_pins_r, port_b_mode_high_pins_r);
      // Output pins excluded so own drive never fires the interrupt
      irq_nxt = |(pin_b_sync & port_b_irq_enables_r
         & ~port_b_direction_r); // R12 R13
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         rdata_r <= 4'h0;
         pad_a_r <= '0;
         pad_b_r <= '0;
         irq_r   <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         pad_a_r <= pad_a_nxt; // R06
         pad_b_r <= pad_b_nxt; // R06
         irq_r   <= irq_nxt;
      end
   end

   assign sfr_rdata_out         = rdata_r;
   assign sfr_hit_out           = hit & (sfr_req_in.rd | sfr_req_in.wr);
   assign port_a_pad_out        = pad_a_r;
   assign port_b_pad_out        = pad_b_r;
   assign external_irq_zero_out = irq_r;
endmodule // qbp_port_pair

/* test/qbp_checker.sv */
// Concurrent checks at the port pair boundary
`timescale 1ns/100ps
module qbp_checker
   import qbp_pkg::*;
(
   // Clock, reset and register access
   input wire logic                  clock_in,
   input wire logic                  rst_in,
   input wire qbp_pkg::qbp_sfr_req_t sfr_req_in,
   input wire logic [3:0]            sfr_rdata_out,
   input wire logic                  sfr_hit_out,
   // Pins and pads
   input wire logic [3:0]            port_a_pin_in,
   input wire qbp_pkg::qbp_pad_t     port_a_pad_out,
   input wire logic [3:0]            port_b_pin_in,
   input wire qbp_pkg::qbp_pad_t     port_b_pad_out,
   input wire logic                  external_irq_zero_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   logic mapped;
   assign mapped = sfr_req_in.addr inside {QBP_ADDR_A_DATA, QBP_ADDR_B_DATA,
      QBP_ADDR_A_MODE_LO, QBP_ADDR_A_MODE_HI, QBP_ADDR_A_DIR,
      QBP_ADDR_B_MODE_LO, QBP_ADDR_B_MODE_HI, QBP_ADDR_B_DIR,
      QBP_ADDR_B_IRQ_EN};
   sequence s_wr_b;
      sfr_req_in.wr && sfr_req_in.addr == QBP_ADDR_B_DATA;
   endsequence
   sequence s_quiet_b;
      port_b_pin_in == 4'h0 [*3];
   endsequence
   a_hit_decode: assert property (sfr_hit_out ==
      ((sfr_req_in.wr || sfr_req_in.rd) && mapped)) else $error("bad hit");
   a_data_cleared: assert property ($fell(rst_in) |->
      (port_a_pad_out.out | port_b_pad_out.out | port_b_pad_out.oe) == 4'h0)
      else $error("pads not cleared");
   a_pull_down_init: assert property ($fell(rst_in) |=>
      (port_a_pad_out.pull_down & port_b_pad_out.pull_down) == 4'hF)
      else $error("no initial pull-down");
   a_b_write_pad: assert property (s_wr_b |-> ##2
      port_b_pad_out.out == $past(sfr_req_in.wdata, 2))
      else $error("pad late or wrong");
   a_pad_not_early: assert property (!sfr_req_in.wr [*2] |=>
      $stable(port_b_pad_out.out)) else $error("pad moved early");
   a_oe_no_pull: assert property ((port_b_pad_out.oe &
      (port_b_pad_out.pull_up | port_b_pad_out.pull_down)) == 4'h0)
      else $error("pull on driven pin");
   a_pull_exclusive: assert property ((port_a_pad_out.pull_up &
      port_a_pad_out.pull_down) == 4'h0) else $error("both pulls on");
   a_rdata_idle: assert property (!(sfr_req_in.rd && sfr_hit_out) |=>
      sfr_rdata_out == 4'h0) else $error("read data not idle");
   a_irq_quiet: assert property (s_quiet_b |=>
      !external_irq_zero_out) else $error("interrupt without pin");
endmodule // qbp_checker

bind qbp_port_pair qbp_checker qbp_checker_inst (
   .clock_in(clock_in), .rst_in(rst_in), .sfr_req_in(sfr_req_in),
   .sfr_rdata_out(sfr_rdata_out), .sfr_hit_out(sfr_hit_out),
   .port_a_pin_in(port_a_pin_in), .port_a_pad_out(port_a_pad_out),
   .port_b_pin_in(port_b_pin_in), .port_b_pad_out(port_b_pad_out),
   .external_irq_zero_out(external_irq_zero_out));

/* test/qbp_board.sv */
// Board model: pad drive, pulls and an external source per pin
`timescale 1ns/100ps
module qbp_board
   import qbp_pkg::*;
(
   // Clock and pad controls
   input  wire logic              clock_in,
   input  wire qbp_pkg::qbp_pad_t pad_in,
   // External source and resulting level
   input  wire logic [3:0]        ext_en_in,
   input  wire logic [3:0]        ext_val_in,
   output logic      [3:0]        pin_out
);
   logic [3:0] float_r = 4'h5;
   // Floating pins wander, so a stale level never passes
   always @(posedge clock_in) float_r <= ~float_r;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (pad_in.oe[i]) pin_out[i] = pad_in.out[i];
         else if (ext_en_in[i]) pin_out[i] = ext_val_in[i];
         else if (pad_in.pull_up[i]) pin_out[i] = 1'b1;
         else if (pad_in.pull_down[i]) pin_out[i] = 1'b0;
         else pin_out[i] = float_r[i];
      end
   end
endmodule // qbp_board

/* test/tb_qbp_port_pair.sv */
// Self-checking bench for the two bidirectional ports
`timescale 1ns/100ps
module tb_qbp_port_pair;
   import qbp_pkg::*;
   logic         clock_in = 1'b0;
   logic         rst_in   = 1'b1;
   qbp_sfr_req_t req      = '0;
   logic [3:0]   ext_en   = 4'h0;
   logic [3:0]   ext_val  = 4'h0;
   logic [3:0]   rdata, pin_a, pin_b, d, oe_tab;
   logic         hit, irq;
   qbp_pad_t     pad_a, pad_b;
   int           n_fail = 0, samples_checked = 0, i, c, v;
   logic [7:0]   regs [7] = '{QBP_ADDR_A_MODE_LO, QBP_ADDR_A_MODE_HI,
      QBP_ADDR_A_DIR, QBP_ADDR_B_MODE_LO, QBP_ADDR_B_MODE_HI,
      QBP_ADDR_B_DIR, QBP_ADDR_B_IRQ_EN};
   qbp_port_pair qbp_port_pair_inst (.clock_in(clock_in), .rst_in(rst_in),
      .sfr_req_in(req), .sfr_rdata_out(rdata), .sfr_hit_out(hit),
      .port_a_pin_in(pin_a), .port_a_pad_out(pad_a),
      .port_b_pin_in(pin_b), .port_b_pad_out(pad_b),
      .external_irq_zero_out(irq));
   qbp_board qbp_board_inst (.clock_in(clock_in), .pad_in(pad_a),
      .ext_en_in(ext_en), .ext_val_in(ext_val), .pin_out(pin_a));
   qbp_board qbp_board_b_inst (.clock_in(clock_in), .pad_in(pad_b),
      .ext_en_in(ext_en), .ext_val_in(ext_val), .pin_out(pin_b));
   always #50 clock_in = ~clock_in;
   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask
   task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One idle edge after each access, so back-to-back calls never
   // assign the request twice in one time step
   task automatic wr(input logic [7:0] a, input logic [3:0] x);
      req = {1'b1, 1'b0, a, x};
      tick(1);
      req = '0;
      tick(1);
   endtask
   task automatic rd(input logic [7:0] a, output logic [3:0] x);
      req = {1'b0, 1'b1, a, 4'h0};
      tick(1);
      x = rdata;
      req = '0;
      tick(1);
   endtask
   task automatic wait_irq(input logic e);
      for (int k = 0; k < 8 && irq !== e; k++) tick(1);
      chk({3'h0, irq}, {3'h0, e});
      if (irq !== e) results();
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      tick(16);
      rst_in = 1'b0;
      tick(3);
      for (i = 0; i < 7; i++) begin
         rd(regs[i], d);
         chk(d, 4'h0);
      end
      for (i = 0; i < 7; i++) wr(regs[i], 4'(i + 6));
      for (i = 0; i < 7; i++) begin
         rd(regs[i], d);
         chk(d, 4'(i + 6));
      end
      // Unmapped place: refused, reads zero
      req = {1'b0, 1'b1, 8'h0C, 4'h0};
      #1 chk({3'h0, hit}, 4'h0);
      tick(1);
      req = '0;
      chk(rdata, 4'h0);
      tick(1);
      // Mixed directions: outputs read data, inputs read pins
      wr(QBP_ADDR_B_IRQ_EN, 4'h0);
      wr(QBP_ADDR_B_MODE_LO, 4'h0);
      wr(QBP_ADDR_B_MODE_HI, 4'h0);
      wr(QBP_ADDR_B_DIR, 4'h3);
      wr(QBP_ADDR_B_DATA, 4'hA);
      ext_en = 4'hC;
      ext_val = 4'h4;
      tick(3);
      chk(pad_b.out, 4'hA);
      chk(pad_b.oe, 4'h3);
      chk(pin_b, 4'h6);
      rd(QBP_ADDR_B_DATA, d);
      chk(d, 4'h6);
      wr(QBP_ADDR_A_MODE_LO, 4'h0);
      wr(QBP_ADDR_A_MODE_HI, 4'h0);
      wr(QBP_ADDR_A_DIR, 4'hF);
      wr(QBP_ADDR_A_DATA, 4'h9);
      tick(2);
      chk(pin_a, 4'h9);
      rd(QBP_ADDR_A_DATA, d);
      chk(d, 4'h9);
      // Every mode code on output pin 0 and input pin 1
      wr(QBP_ADDR_B_DIR, 4'h1);
      for (v = 0; v < 2; v++) begin
         wr(QBP_ADDR_B_DATA, 4'(v));
         oe_tab = v ? 4'h5 : 4'h3;
         for (c = 0; c < 4; c++) begin
            wr(QBP_ADDR_B_MODE_LO, {2'(c), 2'(c)});
            tick(2);
            chk({3'h0, pad_b.oe[0]}, {3'h0, oe_tab[c]});
            chk({3'h0, pad_b.pull_up[1]}, {3'h0, c == 2});
            chk({3'h0, pad_b.pull_down[1]}, {3'h0, c == 0});
         end
      end
      // Interrupt OR with per-pin enables
      wr(QBP_ADDR_B_DIR, 4'h0);
      ext_en = 4'hF;
      wr(QBP_ADDR_B_IRQ_EN, 4'hB);
      tick(4);
      chk({3'h0, irq}, 4'h0);
      wr(QBP_ADDR_B_IRQ_EN, 4'h4);
      wait_irq(1'b1);
      ext_val = 4'h0;
      wait_irq(1'b0);
      results();
   end
endmodule // tb_qbp_port_pair
